/* File: logic/tce_core.sv */
// execution unit of a small 8-bit core: alu, flags, branches, skips and i/o bit operations
//
// Contract
// - add two registers, optionally with carry; write sum; update Z C N V H; one clock.
// - subtract register or constant, optionally with carry; write; update Z C N V H.
// - and, or, xor write destination, update Z N V only; carry kept. The code also updates S.
// - test ands register with itself, value kept, updates Z N V.
// - set-bits ors mask in; clear-bits ands complement; both update Z N V.
// - flag branch loads pc plus offset plus one; two clocks taken, one not.
// - signed branches use N xor V: ge when zero, lt when one.
// - unsigned branches test carry; equal and not-equal test zero.
// - i/o bit skip passes next instruction when bit matches; one or two clocks.
// - compare-skip-equal skips next when registers equal, no flags changed.
// - compares compute difference unstored, update Z N V C H, one clock.
// - bit store copies register bit into T, only T changes.
// - bit load copies T into destination bit, no flags changed.
// - i/o bit set and clear force the bit, no flags, two clocks.
// - rotate up: bit0 from carry, old bit7 to carry, update Z C N V.
// - rotate down: bit7 from carry, old bit0 to carry, update Z C N V.
// - single flag set and clear force only the named flag, one clock.
// - interrupt-state branches test global interrupt flag with relative offset.
`include "tce_defines.svh"

module tce_core (
    input  wire logic                 clk_i,        // system clock, 100 MHz
    input  wire logic                 rst_i,        // synchronous reset, active high
    input  wire logic [15:0]          instr_i,      // program word at pc_o, same cycle
    input  wire logic [7:0]           io_rd_data_i, // i/o register addressed by io_addr_o
    output logic      [`TCE_PC_W-1:0] pc_o,         // fetch address
    output logic      [5:0]           io_addr_o,    // i/o register address
    output logic                      io_wr_o,      // i/o write strobe
    output logic      [7:0]           io_wr_data_o, // i/o write data
    output logic      [7:0]           status_o,     // status flags register
    output logic                      retire_o,     // one instruction completed
    output logic                      rf_we_o,      // register write took place
    output logic      [4:0]           rf_addr_o,    // register written
    output logic      [7:0]           rf_data_o     // value written
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic tce_pkg::tce_alu_t addsub(input logic [7:0] a, input logic [7:0] b,
                                                 input logic cin, input logic sub);
        tce_pkg::tce_alu_t o;
        o.r = sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
        if (sub)
        begin
            o.h = (~a[3] & b[3]) | (b[3] & o.r[3]) | (o.r[3] & ~a[3]);
            o.c = (~a[7] & b[7]) | (b[7] & o.r[7]) | (o.r[7] & ~a[7]);
            o.v = (a[7] & ~b[7] & ~o.r[7]) | (~a[7] & b[7] & o.r[7]);
        end
        else
        begin
            o.h = (a[3] & b[3]) | (b[3] & ~o.r[3]) | (~o.r[3] & a[3]);
            o.c = (a[7] & b[7]) | (b[7] & ~o.r[7]) | (~o.r[7] & a[7]);
            o.v = (a[7] & b[7] & ~o.r[7]) | (~a[7] & ~b[7] & o.r[7]);
        end
        return o;
    endfunction

    function automatic logic [7:0] arith_flags(input logic [7:0] f, input tce_pkg::tce_alu_t a);
        logic [7:0] n;
        n = f;
        n[`TCE_F_H] = a.h;
        n[`TCE_F_V] = a.v;
        n[`TCE_F_C] = a.c;
        n[`TCE_F_N] = a.r[7];
        n[`TCE_F_Z] = (a.r == 8'h00);
        n[`TCE_F_S] = a.r[7] ^ a.v;
        return n;
    endfunction

    // zero, negative and sign from the result, overflow cleared; carry and half carry untouched
    function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] r);
        logic [7:0] n;
        n = f;
        n[`TCE_F_V] = 1'b0;
        n[`TCE_F_N] = r[7];
        n[`TCE_F_Z] = (r == 8'h00);
        n[`TCE_F_S] = r[7];
        return n;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]           rf_q [32];
    logic [`TCE_PC_W-1:0] pc_q;
    logic [15:0]          ir_q;
    logic                 ir_v_q;
    logic                 io_ph_q;
    logic [7:0]           status_flags_register_q;

    // ****************************************************************
    // decode
    // ****************************************************************
    wire                  imm_w  = ir_q[`TCE_IMM_BIT];
    wire [4:0]            d_idx  = imm_w ? {1'b1, ir_q[`TCE_ID_HI:`TCE_ID_LO]} : ir_q[`TCE_RD_HI:`TCE_RD_LO];
    wire [4:0]            r_idx  = ir_q[`TCE_RR_HI:`TCE_RR_LO];
    wire [7:0]            kimm   = ir_q[`TCE_K_HI:`TCE_K_LO];
    wire [2:0]            bsel   = ir_q[`TCE_B_HI:`TCE_B_LO];
    wire [7:0]            bmask  = 8'h01 << bsel;
    wire [6:0]            koff   = ir_q[`TCE_OFF_HI:`TCE_OFF_LO];
    wire [`TCE_PC_W-1:0]  target = pc_q + {{(`TCE_PC_W-7){koff[6]}}, koff};
    wire [7:0]            rd_v   = rf_q[d_idx];
    wire [7:0]            rr_v   = imm_w ? kimm : rf_q[r_idx];
    wire                  cflag  = status_flags_register_q[`TCE_F_C];
    wire                  nxv    = status_flags_register_q[`TCE_F_N] ^ status_flags_register_q[`TCE_F_V];
    // a bubble decodes as no operation, so it never writes or branches
    wire tce_pkg::tce_op_t op_w  = !ir_v_q ? tce_pkg::no_operation_op :
                                   imm_w ? tce_pkg::tce_op_t'({3'b100, ir_q[`TCE_IOP_HI:`TCE_IOP_LO]}) :
                                   tce_pkg::tce_op_t'({1'b0, ir_q[`TCE_ROP_HI:`TCE_ROP_LO]});
    wire                  io_op  = (op_w == tce_pkg::io_bit_set_op) || (op_w == tce_pkg::io_bit_clear_op);
    wire                  stall  = io_op && !io_ph_q;

    // ****************************************************************
    // execute
    // ****************************************************************
    logic [7:0]        res;
    logic              wr;
    logic [7:0]        nf;
    logic              jump;
    logic              skip;
    tce_pkg::tce_alu_t al;

    always_comb
    begin
        res  = rd_v;
        wr   = 1'b0;
        nf   = status_flags_register_q;
        jump = 1'b0;
        skip = 1'b0;
        al   = addsub(rd_v, rr_v, 1'b0, 1'b1);
        unique case (op_w)
            tce_pkg::add_op, tce_pkg::add_with_carry_op:
            begin
                al  = addsub(rd_v, rr_v, (op_w == tce_pkg::add_with_carry_op) & cflag, 1'b0);
                res = al.r;
                wr  = 1'b1;
                nf  = arith_flags(status_flags_register_q, al);
            end
            tce_pkg::subtract_op, tce_pkg::subtract_immediate_op,
            tce_pkg::subtract_with_borrow_op, tce_pkg::subtract_borrow_immediate_op:
            begin
                al  = addsub(rd_v, rr_v, cflag & ((op_w == tce_pkg::subtract_with_borrow_op) ||
                                                  (op_w == tce_pkg::subtract_borrow_immediate_op)), 1'b1);
                res = al.r;
                wr  = 1'b1;
                nf  = arith_flags(status_flags_register_q, al);
            end
            tce_pkg::compare_op, tce_pkg::compare_immediate_op, tce_pkg::compare_with_carry_op:
            begin
                al = addsub(rd_v, rr_v, cflag & (op_w == tce_pkg::compare_with_carry_op), 1'b1);
                nf = arith_flags(status_flags_register_q, al);
            end
            tce_pkg::and_op, tce_pkg::and_immediate_op:
            begin
                res = rd_v & rr_v;
                wr  = 1'b1;
                nf  = logic_flags(status_flags_register_q, rd_v & rr_v);
            end
            tce_pkg::or_op, tce_pkg::or_immediate_op, tce_pkg::set_masked_bits_op:
            begin
                res = rd_v | rr_v;
                wr  = 1'b1;
                nf  = logic_flags(status_flags_register_q, rd_v | rr_v);
            end
            tce_pkg::clear_masked_bits_op:
            begin
                res = rd_v & ~rr_v;
                wr  = 1'b1;
                nf  = logic_flags(status_flags_register_q, rd_v & ~rr_v);
            end
            tce_pkg::exclusive_or_op:
            begin
                res = rd_v ^ rr_v;
                wr  = 1'b1;
                nf  = logic_flags(status_flags_register_q, rd_v ^ rr_v);
            end
            tce_pkg::zero_minus_test_op:
                nf = logic_flags(status_flags_register_q, rd_v & rd_v);
            tce_pkg::load_immediate_op:
            begin
                res = kimm;
                wr  = 1'b1;
            end
            tce_pkg::compare_skip_equal_op:
                skip = (rd_v == rr_v);
            tce_pkg::rotate_up_via_carry_op, tce_pkg::rotate_down_via_carry_op:
            begin
                res = (op_w == tce_pkg::rotate_up_via_carry_op) ? {rd_v[6:0], cflag} : {cflag, rd_v[7:1]};
                wr  = 1'b1;
                nf  = logic_flags(status_flags_register_q, res);
                nf[`TCE_F_C] = (op_w == tce_pkg::rotate_up_via_carry_op) ? rd_v[7] : rd_v[0];
                nf[`TCE_F_V] = res[7] ^ nf[`TCE_F_C];
                nf[`TCE_F_S] = nf[`TCE_F_C];
            end
            tce_pkg::bit_to_transfer_flag_op:
                nf[`TCE_F_T] = rd_v[bsel];
            tce_pkg::transfer_flag_to_bit_op:
            begin
                res[bsel] = status_flags_register_q[`TCE_F_T];
                wr        = 1'b1;
            end
            tce_pkg::flag_set_op:
                nf = status_flags_register_q | bmask;
            tce_pkg::flag_clear_op:
                nf = status_flags_register_q & ~bmask;
            // flag index 0 gives carry branches, 1 zero, 7 the interrupt enable
            tce_pkg::branch_flag_high_op:
                jump = status_flags_register_q[bsel];
            tce_pkg::branch_flag_low_op:
                jump = !status_flags_register_q[bsel];
            tce_pkg::branch_signed_ge_op:
                jump = !nxv;
            tce_pkg::branch_signed_lt_op:
                jump = nxv;
            tce_pkg::skip_io_bit_low_op:
                skip = !io_rd_data_i[bsel];
            tce_pkg::skip_io_bit_high_op:
                skip = io_rd_data_i[bsel];
            tce_pkg::no_operation_op, tce_pkg::io_bit_set_op, tce_pkg::io_bit_clear_op:
                res = rd_v;
            default:
                res = rd_v;
        endcase
    end

    // ****************************************************************
    // sequencing
    // ****************************************************************
    // the fetched word is dropped on a taken branch or skip: this bubble is the second clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_q         <= `TCE_PC_RST;
            ir_q         <= `TCE_IR_RST;
            ir_v_q       <= 1'b0;
            io_ph_q      <= 1'b0;
            status_flags_register_q       <= `TCE_STATUS_FLAGS_REGISTER_RST;
            io_addr_o    <= `TCE_IOA_RST;
            io_wr_o      <= 1'b0;
            io_wr_data_o <= `TCE_BYTE_RST;
            retire_o     <= 1'b0;
        end
        else if (stall)
        begin
            io_ph_q      <= 1'b1;
            io_wr_o      <= 1'b1;
            io_wr_data_o <= (op_w == tce_pkg::io_bit_set_op) ? (io_rd_data_i | bmask) : (io_rd_data_i & ~bmask);
            retire_o     <= 1'b0;
        end
        else
        begin
            io_ph_q   <= 1'b0;
            io_wr_o   <= 1'b0;
            ir_q      <= instr_i;
            ir_v_q    <= !(jump || skip);
            pc_q      <= jump ? target : `TCE_PC_W'(pc_q + 1'b1);
            io_addr_o <= instr_i[`TCE_P_HI:`TCE_P_LO];
            status_flags_register_q    <= nf;
            retire_o  <= ir_v_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rf_we_o <= 1'b0;
        else
            rf_we_o <= wr;
        rf_addr_o <= d_idx;
        rf_data_o <= res;
        if (wr)
            rf_q[d_idx] <= res;
    end

    assign pc_o     = pc_q;
    assign status_o = status_flags_register_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ADD_SUM: assert property ((op_w == tce_pkg::add_op) |=>
        rf_we_o && rf_data_o == $past(8'(rd_v + rr_v)) && retire_o)
        else $error("add result or write wrong");
    AST_SUB_BORROW: assert property ((op_w == tce_pkg::subtract_op) |=>
        rf_data_o == $past(8'(rd_v - rr_v)) && status_o[`TCE_F_C] == $past(rr_v > rd_v))
        else $error("subtract result or borrow wrong");
    AST_LOGIC_KEEPS_C: assert property ((op_w == tce_pkg::exclusive_or_op || op_w == tce_pkg::and_op) |=>
        status_o[`TCE_F_C] == $past(cflag) && !status_o[`TCE_F_V])
        else $error("logic op touched carry or left overflow");
    AST_CMP_NO_WRITE: assert property ((op_w == tce_pkg::compare_op) |=>
        !rf_we_o && status_o[`TCE_F_Z] == $past(rd_v == rr_v))
        else $error("compare wrote a register or set zero wrongly");
    AST_BRANCH_TAKEN: assert property (jump |=> pc_o == $past(target) && !ir_v_q ##1 !retire_o)
        else $error("taken branch target or bubble wrong");
    AST_SIGNED_GE: assert property ((op_w == tce_pkg::branch_signed_ge_op) |-> jump == !nxv)
        else $error("signed branch condition wrong");
    AST_SKIP: assert property (skip |=> !ir_v_q && pc_o == $past(pc_q) + 1'b1)
        else $error("skip did not drop the next word");
    AST_IO_TWO_CLOCKS: assert property (stall |=> io_wr_o && $stable(pc_o) && $stable(status_o) ##1 !io_wr_o)
        else $error("i/o bit operation timing wrong");
    AST_BIT_STORE: assert property ((op_w == tce_pkg::bit_to_transfer_flag_op) |=>
        status_o[`TCE_F_T] == $past(rd_v[bsel]) && status_o[5:0] == $past(status_flags_register_q[5:0]))
        else $error("bit store changed more than the transfer flag");
    AST_ROTATE_UP: assert property ((op_w == tce_pkg::rotate_up_via_carry_op) |=>
        status_o[`TCE_F_C] == $past(rd_v[7]) && rf_data_o[0] == $past(cflag))
        else $error("rotate up carry path wrong");
    AST_FLAG_SET: assert property ((op_w == tce_pkg::flag_set_op) |=> status_o == $past(status_flags_register_q | bmask))
        else $error("flag set changed other flags");

endmodule

/* File: logic/tce_defines.svh */
// constants of the tiny core execution unit: widths, fields, flag positions, reset values
`ifndef TCE_DEFINES_SVH
`define TCE_DEFINES_SVH

`define TCE_PC_W      9
`define TCE_PC_RST    9'h000
`define TCE_IR_RST    16'h0000
`define TCE_STATUS_FLAGS_REGISTER_RST  8'h00
`define TCE_BYTE_RST  8'h00
`define TCE_IOA_RST   6'h00

// status flag bit positions
`define TCE_F_C       0
`define TCE_F_Z       1
`define TCE_F_N       2
`define TCE_F_V       3
`define TCE_F_S       4
`define TCE_F_H       5
`define TCE_F_T       6
`define TCE_F_I       7

// instruction word fields
`define TCE_IMM_BIT   15
`define TCE_ROP_HI    14
`define TCE_ROP_LO    10
`define TCE_IOP_HI    14
`define TCE_IOP_LO    12
`define TCE_RD_HI     9
`define TCE_RD_LO     5
`define TCE_RR_HI     4
`define TCE_RR_LO     0
`define TCE_ID_HI     11
`define TCE_ID_LO     8
`define TCE_K_HI      7
`define TCE_K_LO      0
`define TCE_OFF_HI    9
`define TCE_OFF_LO    3
`define TCE_P_HI      8
`define TCE_P_LO      3
`define TCE_B_HI      2
`define TCE_B_LO      0

`endif

/* File: logic/tce_pkg.sv */
// types of the tiny core execution unit
package tce_pkg;

    typedef enum logic [5:0] {
        no_operation_op              = 6'b000000,
        add_op                       = 6'b000001,
        add_with_carry_op            = 6'b000010,
        subtract_op                  = 6'b000011,
        subtract_with_borrow_op      = 6'b000100,
        and_op                       = 6'b000101,
        or_op                        = 6'b000110,
        exclusive_or_op              = 6'b000111,
        compare_op                   = 6'b001000,
        compare_with_carry_op        = 6'b001001,
        compare_skip_equal_op        = 6'b001010,
        zero_minus_test_op           = 6'b001011,
        rotate_up_via_carry_op       = 6'b001100,
        rotate_down_via_carry_op     = 6'b001101,
        bit_to_transfer_flag_op      = 6'b001110,
        transfer_flag_to_bit_op      = 6'b001111,
        flag_set_op                  = 6'b010000,
        flag_clear_op                = 6'b010001,
        branch_flag_high_op          = 6'b010010,
        branch_flag_low_op           = 6'b010011,
        branch_signed_ge_op          = 6'b010100,
        branch_signed_lt_op          = 6'b010101,
        io_bit_set_op                = 6'b010110,
        io_bit_clear_op              = 6'b010111,
        skip_io_bit_low_op           = 6'b011000,
        skip_io_bit_high_op          = 6'b011001,
        subtract_immediate_op        = 6'b100000,
        subtract_borrow_immediate_op = 6'b100001,
        and_immediate_op             = 6'b100010,
        or_immediate_op              = 6'b100011,
        compare_immediate_op         = 6'b100100,
        set_masked_bits_op           = 6'b100101,
        clear_masked_bits_op         = 6'b100110,
        load_immediate_op            = 6'b100111
    } tce_op_t;

    typedef struct packed {
        logic       h;
        logic       v;
        logic       c;
        logic [7:0] r;
    } tce_alu_t;

endpackage

/* File: sim/tce_mem_model.sv */
// program memory and i/o register space on the far side of the execution unit
module tce_mem_model (
    input  wire logic        clk_i,        // system clock
    input  wire logic [8:0]  pc_i,         // fetch address
    input  wire logic [5:0]  io_addr_i,    // i/o register address
    input  wire logic        io_wr_i,      // i/o write strobe
    input  wire logic [7:0]  io_wr_data_i, // i/o write data
    output logic      [15:0] instr_o,      // program word at pc_i
    output logic      [7:0]  io_rd_data_o  // i/o register contents
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] prog   [512];
    logic [7:0]  io_reg [64];
    initial
    begin
        foreach (prog[i]) prog[i] = 16'h0000;
        foreach (io_reg[i]) io_reg[i] = 8'h00;
    end
    // reads are combinational, as the core samples them in its execute cycle
    assign instr_o      = prog[pc_i];
    assign io_rd_data_o = io_reg[io_addr_i];
    // the write lands at the end of the strobe cycle, so a read-modify-write sees the old byte
    always @(posedge clk_i)
    begin
        if (io_wr_i === 1'b1)
            io_reg[io_addr_i] <= io_wr_data_i;
    end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the tiny core execution unit
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i;
    logic        rst_i;
    logic [15:0] instr;
    logic [7:0]  io_rd;
    logic [8:0]  pc_o;
    logic [5:0]  io_addr_o;
    logic        io_wr_o;
    logic [7:0]  io_wr_data_o;
    logic [7:0]  status_o;
    logic        retire_o;
    logic        rf_we_o;
    logic [4:0]  rf_addr_o;
    logic [7:0]  rf_data_o;
    int          err_total;
    int          check_count;
    int          nret;
    int          cyc;
    int          wr_cnt;
    logic [7:0]  st_log [64];
    logic [7:0]  rd_log [64];
    logic        we_log [64];
    logic [4:0]  ad_log [64];
    int          cy_log [64];
    logic [15:0] pg     [$];

    tce_core u_tce_core (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr), .io_rd_data_i(io_rd), .pc_o(pc_o),
        .io_addr_o(io_addr_o), .io_wr_o(io_wr_o), .io_wr_data_o(io_wr_data_o), .status_o(status_o),
        .retire_o(retire_o), .rf_we_o(rf_we_o), .rf_addr_o(rf_addr_o), .rf_data_o(rf_data_o));
    tce_mem_model u_tce_mem_model (.clk_i(clk_i), .pc_i(pc_o), .io_addr_i(io_addr_o), .io_wr_i(io_wr_o),
        .io_wr_data_i(io_wr_data_o), .instr_o(instr), .io_rd_data_o(io_rd));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ****************
    // helpers
    // ****************
    function automatic logic [15:0] rr(tce_pkg::tce_op_t op, logic [4:0] d, logic [4:0] r);
        return {1'b0, op[4:0], d, r};
    endfunction
    // branch, flag and i/o forms share the layout: 7-bit field at [9:3], index at [2:0]
    function automatic logic [15:0] bx(tce_pkg::tce_op_t op, logic [6:0] k, logic [2:0] s);
        return {1'b0, op[4:0], k, s};
    endfunction
    function automatic logic [15:0] im(tce_pkg::tce_op_t op, logic [3:0] d, logic [7:0] k);
        return {1'b1, op[2:0], d, k};
    endfunction
    function automatic logic [15:0] li(logic [3:0] d, logic [7:0] k);
        return im(tce_pkg::load_immediate_op, d, k);
    endfunction

    always @(posedge clk_i)
    begin
        #2;
        cyc++;
        if (io_wr_o === 1'b1)
            wr_cnt++;
        if (retire_o === 1'b1 && nret < 64)
        begin
            st_log[nret] = status_o;
            rd_log[nret] = rf_data_o;
            we_log[nret] = rf_we_o;
            ad_log[nret] = rf_addr_o;
            cy_log[nret] = cyc;
            nret++;
        end
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chki(input string nm, input int e, input int g);
        check_count++;
        if (g != e)
        begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // loads pg, resets, and runs until n instructions retired; the log keeps what each one left
    task automatic run(input int n);
        int i;
        foreach (pg[j]) u_tce_mem_model.prog[j] = pg[j];
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk8("status_rst", 8'h00, status_o);
        chk8("pc_rst", 8'h00, pc_o[7:0]);
        rst_i = 1'b0;
        cyc = 0;
        nret = 0;
        wr_cnt = 0;
        i = 0;
        while (nret < n && i < 200)
        begin
            @(posedge clk_i);
            #3;
            i++;
        end
        chki("retires", n, nret);
        foreach (pg[j]) u_tce_mem_model.prog[j] = 16'h0000;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_arith();
        logic [7:0] ed [5] = '{8'h00, 8'hE3, 8'hFF, 8'hFE, 8'h02};
        logic [7:0] es [5] = '{8'h23, 8'h0C, 8'h35, 8'h14, 8'h21};
        pg = '{li(4'h0, 8'h8F), li(4'h1, 8'h71), rr(tce_pkg::add_op, 5'h10, 5'h11),
               rr(tce_pkg::add_with_carry_op, 5'h11, 5'h11), im(tce_pkg::subtract_immediate_op, 4'h1, 8'hE4),
               im(tce_pkg::subtract_borrow_immediate_op, 4'h1, 8'h00), rr(tce_pkg::subtract_op, 5'h10, 5'h11)};
        run(7);
        for (int i = 0; i < 5; i++)
        begin
            chk8("arith_result", ed[i], rd_log[i + 2]);
            chk8("arith_flags", es[i], st_log[i + 2]);
        end
        chki("arith_cycles", 6, cy_log[6] - cy_log[0]);
        chk8("arith_addr", 8'h10, {3'h0, ad_log[6]});
    endtask

    task automatic t_logic();
        logic [7:0] ed [5] = '{8'h30, 8'hB0, 8'h00, 8'h81, 8'h80};
        logic [7:0] es [5] = '{8'h01, 8'h15, 8'h03, 8'h15, 8'h15};
        pg = '{li(4'h2, 8'hF0), li(4'h3, 8'h40), bx(tce_pkg::flag_set_op, 7'h00, 3'h0),
               bx(tce_pkg::flag_set_op, 7'h00, 3'h3), im(tce_pkg::and_immediate_op, 4'h2, 8'h3C),
               im(tce_pkg::or_immediate_op, 4'h2, 8'h80), rr(tce_pkg::exclusive_or_op, 5'h12, 5'h12),
               im(tce_pkg::set_masked_bits_op, 4'h2, 8'h81), im(tce_pkg::clear_masked_bits_op, 4'h2, 8'h01),
               rr(tce_pkg::zero_minus_test_op, 5'h13, 5'h00)};
        run(10);
        chk8("flag_set", 8'h09, st_log[3]);
        for (int i = 0; i < 5; i++)
        begin
            chk8("logic_result", ed[i], rd_log[i + 4]);
            chk8("logic_flags", es[i], st_log[i + 4]);
        end
        chk8("test_flags", 8'h01, st_log[9]);
        chk8("test_keeps", 8'h00, {7'h00, we_log[9]});
    endtask

    task automatic t_rot();
        logic [7:0] es [6] = '{8'h19, 8'h0C, 8'h2C, 8'h24, 8'h64, 8'h64};
        pg = '{li(4'h4, 8'h81), rr(tce_pkg::rotate_up_via_carry_op, 5'h14, 5'h00),
               rr(tce_pkg::rotate_down_via_carry_op, 5'h14, 5'h00), bx(tce_pkg::flag_set_op, 7'h00, 3'h5),
               bx(tce_pkg::flag_clear_op, 7'h00, 3'h3), rr(tce_pkg::bit_to_transfer_flag_op, 5'h14, 5'h07),
               rr(tce_pkg::transfer_flag_to_bit_op, 5'h14, 5'h01)};
        run(7);
        chk8("rot_up", 8'h02, rd_log[1]);
        chk8("rot_down", 8'h81, rd_log[2]);
        chk8("bit_load", 8'h83, rd_log[6]);
        for (int i = 0; i < 6; i++)
            chk8("rot_bit_flags", es[i], st_log[i + 1]);
    endtask

    task automatic t_branch();
        int off [8] = '{0, 1, 2, 4, 6, 7, 8, 10};
        int wn;
        pg = '{bx(tce_pkg::flag_set_op, 7'h00, 3'h3), bx(tce_pkg::branch_signed_ge_op, 7'h01, 3'h0),
               bx(tce_pkg::branch_signed_lt_op, 7'h01, 3'h0), li(4'h0, 8'hEE),
               bx(tce_pkg::branch_flag_low_op, 7'h01, 3'h0), li(4'h0, 8'hEE),
               bx(tce_pkg::branch_flag_high_op, 7'h01, 3'h7), bx(tce_pkg::flag_set_op, 7'h00, 3'h7),
               bx(tce_pkg::branch_flag_high_op, 7'h01, 3'h7), li(4'h0, 8'hEE), li(4'h0, 8'h5A)};
        run(8);
        wn = 0;
        for (int i = 0; i < 7; i++)
            wn += (we_log[i] === 1'b1) ? 1 : 0;
        for (int i = 0; i < 8; i++)
            chki("branch_cycle", off[i], cy_log[i] - cy_log[0]);
        chki("branch_writes", 0, wn);
        chk8("branch_target", 8'h5A, rd_log[7]);
        chk8("branch_flags", 8'h08, st_log[2]);
        chk8("branch_flags_i", 8'h88, st_log[7]);
    endtask

    task automatic t_skip();
        int off [9] = '{0, 2, 3, 5, 6, 7, 8, 10, 11};
        u_tce_mem_model.io_reg[5] = 8'h05;
        pg = '{bx(tce_pkg::io_bit_set_op, 7'h05, 3'h1), bx(tce_pkg::io_bit_clear_op, 7'h05, 3'h0),
               bx(tce_pkg::skip_io_bit_low_op, 7'h05, 3'h0), li(4'h0, 8'hEE),
               bx(tce_pkg::skip_io_bit_high_op, 7'h05, 3'h0), li(4'h0, 8'h11), li(4'h1, 8'h11),
               rr(tce_pkg::compare_skip_equal_op, 5'h10, 5'h11), li(4'h0, 8'hEE),
               im(tce_pkg::compare_immediate_op, 4'h1, 8'h12), li(4'h2, 8'h22)};
        run(9);
        for (int i = 0; i < 9; i++)
            chki("skip_cycle", off[i], cy_log[i] - cy_log[0]);
        chk8("io_byte", 8'h06, u_tce_mem_model.io_reg[5]);
        chki("io_writes", 2, wr_cnt);
        chk8("skip_flags", 8'h00, st_log[6]);
        chk8("cmp_flags", 8'h35, st_log[7]);
        chk8("cmp_nowrite", 8'h00, {7'h00, we_log[7]});
        chk8("skip_end", 8'h22, rd_log[8]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #20000;
        err_total++;
        summarize();
    end

    initial
    begin
        err_total = 0;
        check_count = 0;
        nret = 0;
        cyc = 0;
        wr_cnt = 0;
        rst_i = 1'b1;
        t_arith();
        t_logic();
        t_rot();
        t_branch();
        t_skip();
        summarize();
    end
endmodule
